// ==== cic3_decim.sv ====
/*
 CIC3 decimation filter: pin synchronisers, three integrators on the
 modulator bit clock, divider for the decimated clock, three combs, an
 output FIFO and a small register port.
 Assumes the modulator drives its bit clock well below a quarter of
 i_ref_clk and holds the data bit around the rising bit-clock edge.
*/
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "cic_regs.svh"
`default_nettype none

module cic_fifo #(
   parameter int width = 18,
   parameter int depth = 8
) (
   // Clock and reset
   input  wire logic             i_ref_clk,
   input  wire logic             i_rst_n,
   input  wire logic             i_flush,
   // Fill side
   input  wire logic             i_valid,
   output logic                  o_ready,
   input  wire logic [width-1:0] i_data,
   // Drain side
   output logic                  o_valid,
   input  wire logic             i_ready,
   output logic [width-1:0]      o_data,
   output logic [$clog2(depth):0] o_level
);
   localparam int aw = $clog2(depth);
   logic [width-1:0] mem [depth];
   logic [aw-1:0]    wr_ptr;
   logic [aw-1:0]    rd_ptr;
   logic             push;
   logic             pop;

   assign o_ready = (o_level != (aw + 1)'(depth));
   assign o_valid = (o_level != '0);
   assign o_data  = mem[rd_ptr];
   assign push    = i_valid && o_ready;
   assign pop     = o_valid && i_ready;

   always_ff @(posedge i_ref_clk) begin
      if (push) begin
         mem[wr_ptr] <= i_data;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr  <= '0;
         rd_ptr  <= '0;
         o_level <= '0;
      end else if (i_flush) begin
         wr_ptr  <= '0;
         rd_ptr  <= '0;
         o_level <= '0;
      end else begin
         // Pointer wrap relies on a power-of-two depth
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            o_level <= o_level + 1'b1;
         end else if (pop && !push) begin
            o_level <= o_level - 1'b1;
         end
      end
   end
endmodule

module cic3_decim
   import cic_pkg::*;
#(
   parameter int       word_width_param    = 18,
   parameter int       dec_factor          = 5,
   parameter cic_pol_e polarity_param      = CIC_UNIPOLAR,
   parameter bit       output_invert_param = 1'b1
) (
   // Clock and reset
   input  wire logic                        i_ref_clk,
   input  wire logic                        i_rst_n,
   // Modulator pins and clear pin
   input  wire logic                        i_mod_clk,
   input  wire logic                        i_mod_data,
   input  wire logic                        i_reg_clr,
   // Filter output
   output logic                             o_dec_clk,
   output logic [word_width_param-1:0]      o_data,
   // Word stream
   output logic                             o_word_valid,
   input  wire logic                        i_word_ready,
   output logic [word_width_param-1:0]      o_word_data,
   output logic                             o_word_ovf,
   // Register port
   input  wire cic_pkg::cic_addr_t          i_addr,
   input  wire cic_pkg::cic_bus_t           i_wdata,
   input  wire logic                        i_wr,
   input  wire logic                        i_rd,
   output cic_pkg::cic_bus_t                o_rdata
);
   import cic_pkg::*;

   // Growth of a third-order CIC is 3*D bits; never narrower than that
   localparam int aw = (word_width_param > 3 * dec_factor + 1) ?
                       word_width_param : 3 * dec_factor + 1;
   localparam int ww = word_width_param;
   localparam int lw = $clog2(`CIC_FIFO_DEPTH) + 1;
   localparam logic [dec_factor-1:0] cnt_last = '1;
   localparam logic [dec_factor-1:0] cnt_half = dec_factor'(1) << (dec_factor - 1);

   logic [`CIC_SYNC_STAGES-1:0] clk_sync;
   logic [`CIC_SYNC_STAGES-1:0] dat_sync;
   logic [`CIC_SYNC_STAGES-1:0] clr_sync;
   logic                        clk_lvl;
   logic                        clr_lvl;
   logic                        soft_clr;
   logic                        clr;
   logic                        bit_rise;
   logic                        dec_tick;
   logic [dec_factor-1:0]       bit_cnt;
   logic [aw-1:0]               in_step;
   logic [aw-1:0]               integ [3];
   logic [aw-1:0]               comb  [3];
   logic [aw-1:0]               delay [3];
   logic [ww-1:0]               next_out;
   logic                        push;
   logic                        fifo_ready;
   logic [lw-1:0]               fifo_level;
   logic                        fifo_valid;
   logic [ww-1:0]               fifo_head;
   logic                        stage_free;

   // Pin inputs: three flops, a change counts once stages 2 and 3 agree
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         clk_sync <= '0;
         dat_sync <= '0;
         clr_sync <= '0;
      end else begin
         clk_sync <= {clk_sync[1:0], i_mod_clk};
         dat_sync <= {dat_sync[1:0], i_mod_data};
         clr_sync <= {clr_sync[1:0], i_reg_clr};
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         clk_lvl <= 1'b0;
         clr_lvl <= 1'b0;
      end else begin
         if (clk_sync[1] == clk_sync[2]) begin
            clk_lvl <= clk_sync[2];
         end
         if (clr_sync[1] == clr_sync[2]) begin
            clr_lvl <= clr_sync[2];
         end
      end
   end

   assign bit_rise = (clk_sync[1] == clk_sync[2]) && clk_sync[2] && !clk_lvl;
   assign clr      = clr_lvl || soft_clr;
   assign dec_tick = bit_rise && (bit_cnt == cnt_last) && !clr;

   // Bipolar maps the bit to +1/-1, unipolar to 1/0
   always_comb begin
      if (polarity_param == CIC_BIPOLAR) begin
         in_step = dat_sync[2] ? aw'(1) : '1;
      end else begin
         in_step = dat_sync[2] ? aw'(1) : '0;
      end
   end

   // Integrators wrap modulo 2^aw; the combs undo the wrap
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         integ <= '{default: '0};
      end else if (clr) begin
         integ <= '{default: '0};
      end else if (bit_rise) begin
         integ[0] <= integ[0] + in_step;
         integ[1] <= integ[1] + integ[0];
         integ[2] <= integ[2] + integ[1];
      end
   end

   // Divider by 2^dec_factor on bit-clock events
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bit_cnt   <= '0;
         o_dec_clk <= 1'b0;
      end else if (clr) begin
         bit_cnt   <= '0;
         o_dec_clk <= 1'b0;
      end else if (bit_rise) begin
         bit_cnt <= bit_cnt + 1'b1;
         if (dec_tick) begin
            o_dec_clk <= 1'b1;
         end else if (bit_cnt == cnt_half - 1'b1) begin
            o_dec_clk <= 1'b0;
         end
      end
   end

   // Combs step on the same tick that raises o_dec_clk
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         comb  <= '{default: '0};
         delay <= '{default: '0};
      end else if (clr) begin
         comb  <= '{default: '0};
         delay <= '{default: '0};
      end else if (dec_tick) begin
         comb[0]  <= integ[2] - delay[0];
         delay[0] <= integ[2];
         comb[1]  <= comb[0] - delay[1];
         delay[1] <= comb[0];
         comb[2]  <= comb[1] - delay[2];
         delay[2] <= comb[1];
      end
   end

   // Low ww bits; a narrower word than 3*D+1 wraps at full scale
   always_comb begin
      if (output_invert_param) begin
         next_out = comb[2][ww-1:0];
      end else begin
         next_out = ww'(0) - comb[2][ww-1:0];
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_data <= '0;
      end else if (clr) begin
         o_data <= '0;
      end else if (dec_tick) begin
         o_data <= next_out;
      end
   end

   assign push = dec_tick;

   // Filter cannot stall, so a full FIFO drops the word and flags it
   cic_fifo #(
      .width (ww),
      .depth (`CIC_FIFO_DEPTH)
   ) u_fifo (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .i_flush   (clr),
      .i_valid   (push),
      .o_ready   (fifo_ready),
      .i_data    (next_out),
      .o_valid   (fifo_valid),
      .i_ready   (stage_free),
      .o_data    (fifo_head),
      .o_level   (fifo_level)
   );

   // Output stage refills from the head; a stale copy would repeat words
   assign stage_free = !o_word_valid || i_word_ready;

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_word_valid <= 1'b0;
         o_word_data  <= '0;
      end else if (clr) begin
         o_word_valid <= 1'b0;
         o_word_data  <= '0;
      end else if (stage_free) begin
         o_word_valid <= fifo_valid;
         if (fifo_valid) begin
            o_word_data <= fifo_head;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_word_ovf <= 1'b0;
      end else if (push && !fifo_ready) begin
         o_word_ovf <= 1'b1;
      end else if (clr) begin
         o_word_ovf <= 1'b0;
      end else if (i_wr && i_addr == `CIC_STAT_OFS && i_wdata[`CIC_STAT_OVF_BIT]) begin
         o_word_ovf <= 1'b0;
      end
   end

   // Register port; read data one cycle after the strobe
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         soft_clr <= `CIC_CTRL_RST;
      end else if (i_wr && i_addr == `CIC_CTRL_OFS) begin
         soft_clr <= i_wdata[`CIC_CTRL_CLR_BIT];
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= '0;
      end else if (i_rd) begin
         unique case (i_addr)
            `CIC_CTRL_OFS: o_rdata <= {31'h0, soft_clr};
            `CIC_STAT_OFS: o_rdata <= 32'(fifo_level) << `CIC_STAT_LVL_LSB
                                      | {31'h0, o_word_ovf};
            `CIC_WORD_OFS: o_rdata <= 32'(o_data);
            default:       o_rdata <= '0;
         endcase
      end else begin
         o_rdata <= '0;
      end
   end

   // Checks
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   logic [dec_factor:0] ev_cnt;
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ev_cnt <= '0;
      end else if (clr || dec_tick) begin
         ev_cnt <= '0;
      end else if (bit_rise) begin
         ev_cnt <= ev_cnt + 1'b1;
      end
   end

   chk_dec_ratio: assert property (
      dec_tick |-> ev_cnt == (dec_factor + 1)'(cnt_last))
      else $error("decimated clock ratio wrong");
   chk_dec_is_comb: assert property (
      $rose(o_dec_clk) |-> $past(dec_tick) && $changed(delay[0]) || $past(integ[2]) == 0)
      else $error("decimated clock not tied to comb step");
   chk_out_on_rise: assert property (
      $changed(o_data) && !$past(clr) |-> $rose(o_dec_clk))
      else $error("output changed off the decimated edge");
   chk_clr_no_clk: assert property (
      clr |=> !o_dec_clk [*2])
      else $error("decimated clock during clear");
   chk_clr_regs: assert property (
      clr |=> integ[2] == '0 && comb[2] == '0 && o_data == '0)
      else $error("clear left state");
   chk_integ_hold: assert property (
      !bit_rise && !clr |=> $stable(integ[0]) && $stable(integ[2]))
      else $error("integrator moved without bit clock");
   chk_integ_step: assert property (
      bit_rise && !clr |=> integ[1] == $past(integ[1]) + $past(integ[0]))
      else $error("integrator cascade wrong");
   chk_comb_chain: assert property (
      dec_tick |=> comb[0] == $past(integ[2]) - $past(delay[0])
                   && comb[2] == $past(comb[1]) - $past(delay[2]))
      else $error("comb cascade wrong");
   chk_out_sign: assert property (
      dec_tick |=> o_data == (output_invert_param ? $past(comb[2][ww-1:0])
                              : ww'(0) - $past(comb[2][ww-1:0])))
      else $error("output sign handling wrong");

   cov_dec_tick:   cover property (dec_tick ##1 o_dec_clk);
   cov_clr_run:    cover property (o_dec_clk ##1 clr);
   cov_fifo_full:  cover property (push && !fifo_ready);
   cov_word_drain: cover property (o_word_valid && i_word_ready);
endmodule
`default_nettype wire

// ==== cic_mod_model.sv ====
/*
 Behavioural delta-sigma modulator: free-running bit clock and one data bit.
 Assumes the bench selects the bit pattern: 0 zeros, 1 ones, 2 alternating.
*/
`timescale 1ns/1ps
`default_nettype none
module cic_mod_model #(
   parameter int half_ns  = 200,
   parameter int phase_ns = 17
) (
   // Pattern select
   input  wire logic [1:0] i_pattern,
   // Modulator pins
   output logic            o_mod_clk,
   output logic            o_mod_data
);
   logic toggle;
   initial begin
      o_mod_clk = 1'b0;
      o_mod_data = 1'b0;
      toggle = 1'b0;
      // Odd offset keeps the bit clock out of phase with the system clock
      #(phase_ns);
      forever begin
         #(half_ns) o_mod_clk = 1'b1;
         #(half_ns) o_mod_clk = 1'b0;
         toggle = ~toggle;
         // Data moves on the fall, well away from the sampling rise
         o_mod_data = (i_pattern == 2'd1) || (i_pattern == 2'd2 && toggle);
      end
   end
endmodule
`default_nettype wire

// ==== cic_pkg.sv ====
/*
 Types shared by the CIC3 decimation filter.
 Assumes cic_regs.svh supplies the numeric constants.
*/
`default_nettype none
package cic_pkg;
   typedef logic [7:0]  cic_addr_t;
   typedef logic [31:0] cic_bus_t;
   typedef enum logic {
      CIC_UNIPOLAR = 1'b0,
      CIC_BIPOLAR  = 1'b1
   } cic_pol_e;
endpackage
`default_nettype wire

// ==== cic_regs.svh ====
/*
 Register offsets, field positions, reset values and timing counts
 for the CIC3 decimation filter. Definitions only.
*/
`ifndef CIC_REGS_SVH
`define CIC_REGS_SVH

`define CIC_CTRL_OFS       8'h00
`define CIC_STAT_OFS       8'h04
`define CIC_WORD_OFS       8'h08
`define CIC_CTRL_CLR_BIT   0
`define CIC_STAT_OVF_BIT   0
`define CIC_STAT_LVL_LSB   8
`define CIC_CTRL_RST       1'b0
`define CIC_FIFO_DEPTH     8
`define CIC_REF_CLK_HZ     20000000
`define CIC_SYNC_STAGES    3

`endif

// ==== tb_cic3_decim.sv ====
/*
 Self-checking bench: unipolar pass-through and bipolar negating filters
 fed by one modulator model, with register port and output FIFO traffic.
 Assumes cic_pkg, cic3_decim and cic_mod_model are compiled before it.
*/
`timescale 1ns/1ps
`include "cic_regs.svh"
`default_nettype none
module tb_cic3_decim;
   import cic_pkg::*;
   localparam int ww = 18;
   localparam int dd = 3;
   logic            i_ref_clk;
   logic            i_rst_n;
   logic            i_reg_clr;
   logic            i_word_ready;
   logic            i_wr;
   logic            i_rd;
   cic_addr_t       i_addr;
   cic_bus_t        i_wdata;
   cic_bus_t        o_rdata;
   logic [1:0]      pattern;
   logic            mod_clk;
   logic            mod_data;
   logic            o_dec_clk;
   logic            dec2_clk;
   logic [ww-1:0]   o_data;
   logic [ww-1:0]   data2;
   logic [ww-1:0]   data_prev;
   logic            o_word_valid;
   logic [ww-1:0]   o_word_data;
   logic            o_word_ovf;
   logic            dec_prev;
   logic            mon_on;
   int              n_fail = 0;
   int              tests_run = 0;
   int              cyc = 0;
   int              rises = 0;
   int              since = 0;
   int              per_last = 0;
   int              hi_run = 0;
   int              hi_last = 0;
   int              bad_chg = 0;
   int              pops = 0;
   int              bad_word = 0;

   cic_mod_model modl (.i_pattern(pattern), .o_mod_clk(mod_clk), .o_mod_data(mod_data));
   cic3_decim #(.dec_factor(dd)) dut (
      .i_ref_clk, .i_rst_n, .i_mod_clk(mod_clk), .i_mod_data(mod_data), .i_reg_clr,
      .o_dec_clk, .o_data, .o_word_valid, .i_word_ready, .o_word_data, .o_word_ovf,
      .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata);
   cic3_decim #(.dec_factor(dd), .polarity_param(CIC_BIPOLAR), .output_invert_param(1'b0)) dut2 (
      .i_ref_clk, .i_rst_n, .i_mod_clk(mod_clk), .i_mod_data(mod_data), .i_reg_clr,
      .o_dec_clk(dec2_clk), .o_data(data2), .o_word_valid(), .i_word_ready,
      .o_word_data(), .o_word_ovf(), .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata());

   initial begin
      i_ref_clk = 1'b0;
      forever #25 i_ref_clk = ~i_ref_clk;
   end

   // Sampled mid-cycle so registered outputs have settled
   always @(negedge i_ref_clk) begin
      since++;
      if (o_dec_clk === 1'b1) hi_run++;
      if (o_dec_clk === 1'b1 && dec_prev !== 1'b1) begin
         rises++;
         per_last = since;
         since = 0;
      end else if (mon_on && o_data !== data_prev) begin
         bad_chg++;
      end
      if (o_dec_clk !== 1'b1 && dec_prev === 1'b1) begin
         hi_last = hi_run;
         hi_run = 0;
      end
      if (o_word_valid === 1'b1 && i_word_ready === 1'b1) begin
         pops++;
         if (o_word_data !== 18'h00200) bad_word++;
      end
      dec_prev = o_dec_clk;
      data_prev = o_data;
   end

   always @(posedge i_ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         summarize();
      end
   end

   task automatic summarize();
      $display("Checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic reg_wr(input cic_addr_t a, input cic_bus_t d);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask

   task automatic reg_rd(input cic_addr_t a, input cic_bus_t exp, input string what);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1;
      check(what, o_rdata, exp);
      @(posedge i_ref_clk);
   endtask

   task automatic wait_rises(input int n);
      int t;
      int k;
      t = rises + n;
      k = 0;
      while (rises < t && k < 100 * n) begin
         @(posedge i_ref_clk);
         k++;
      end
      check("decimated rises", rises >= t, 1);
   endtask

   task automatic t_filter();
      logic [ww-1:0] e1 [3] = '{18'h00000, 18'h00200, 18'h00100};
      logic [ww-1:0] e2 [3] = '{18'h00200, 18'h3fe00, 18'h00000};
      for (int i = 0; i < 3; i++) begin
         pattern <= 2'(i);
         wait_rises(7);
         check("unipolar word", o_data, e1[i]);
         check("bipolar negated word", data2, e2[i]);
      end
      check("decimated period", per_last, 64);
      check("decimated high time", hi_last, 32);
      check("second clock", dec2_clk, o_dec_clk);
      reg_rd(`CIC_WORD_OFS, 32'h0000_0100, "word register");
      reg_wr(8'h0c, 32'h0000_0001);
      reg_rd(8'h0c, 32'h0, "unmapped read");
      reg_rd(`CIC_CTRL_OFS, 32'h0, "ctrl after unmapped write");
      $display("filter test done");
   endtask

   task automatic t_clear();
      int r;
      pattern <= 2'd1;
      mon_on = 1'b0;
      i_reg_clr <= 1'b1;
      repeat (10) @(posedge i_ref_clk);
      check("word in clear", o_data, 0);
      r = rises;
      repeat (200) @(posedge i_ref_clk);
      check("rises in clear", rises - r, 0);
      i_reg_clr <= 1'b0;
      wait_rises(7);
      check("word after clear", o_data, 18'h00200);
      reg_wr(`CIC_CTRL_OFS, 32'h1);
      reg_rd(`CIC_CTRL_OFS, 32'h1, "ctrl readback");
      r = rises;
      repeat (200) @(posedge i_ref_clk);
      check("rises in soft clear", rises - r, 0);
      check("word in soft clear", data2, 0);
      reg_wr(`CIC_CTRL_OFS, 32'h0);
      wait_rises(7);
      mon_on = 1'b1;
      check("word after soft clear", o_data, 18'h00200);
      $display("clear test done");
   endtask

   task automatic t_fifo();
      int p;
      i_word_ready <= 1'b0;
      wait_rises(11);
      check("overflow pin", o_word_ovf, 1);
      reg_rd(`CIC_STAT_OFS, 32'h0000_0801, "status full");
      repeat (10) @(posedge i_ref_clk);
      bad_word = 0;
      p = pops;
      // Drain mid-period so no push lands while the queue empties
      i_word_ready <= 1'b1;
      repeat (30) @(posedge i_ref_clk);
      // Eight queued words plus the one held in the output stage
      check("words drained", pops - p, 9);
      check("drained data", bad_word, 0);
      check("valid when empty", o_word_valid, 0);
      reg_wr(`CIC_STAT_OFS, 32'h1);
      reg_rd(`CIC_STAT_OFS, 32'h0, "status cleared");
      check("overflow pin cleared", o_word_ovf, 0);
      $display("fifo test done");
   endtask

   task automatic t_reset();
      mon_on = 1'b0;
      i_rst_n <= 1'b0;
      #1;
      check("word in reset", o_data, 0);
      check("bipolar word in reset", data2, 0);
      @(posedge i_ref_clk);
      @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      wait_rises(7);
      mon_on = 1'b1;
      check("word after reset", o_data, 18'h00200);
      $display("reset test done");
   endtask

   initial begin
      mon_on = 1'b0;
      dec_prev = 1'b0;
      data_prev = '0;
      i_rst_n = 1'b0;
      i_reg_clr = 1'b0;
      i_word_ready = 1'b1;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = '0;
      i_wdata = '0;
      pattern = 2'd1;
      repeat (2) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      mon_on = 1'b1;
      t_filter();
      t_clear();
      t_fifo();
      t_reset();
      check("stray word changes", bad_chg, 0);
      summarize();
   end
endmodule
`default_nettype wire
